// [logic/lsp_pkg.sv]
// Constants, register map and types of the library safety panel block.
// Function
// - Door open, stop press or actuator overcurrent raises the fault state.
// - Fault removes motor drive well within 100 ms.
// - Broken light curtain holds fault and inhibits all actuator motion.
// - Carousel home only when home and face beams interrupted together.
// - After home, count carousel faces from face flags relative to home.
// - Vertical home on upper beam, lower limit on lower beam.
// - Fault lamp lit for door, rear panel, stop or system failure.
// - Each standby press toggles online and offline.
// - Standby lamp lit while offline.
// - Host commands refused while offline.
// - Arrow buttons jog carousel only while offline, ignored online.
// - Stop press removes power from all robotic equipment.
// - Status display shows a code for the operating state.
// - Place: advance to partial seat, then release while pusher extends.
// - Conveyor and insert/eject motors and solenoids driven open loop by PWM.
// - Front door open or rear panel removed faults and stops motors at once.
// - Rear interlock in override position reads closed.
package lsp_pkg;
	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_PWM_CONV = 8'h08;
	localparam logic [7:0] OFF_PWM_IEU = 8'h0C;
	localparam logic [7:0] OFF_POSITION = 8'h10;
	// ---------------------------------------------------------------
	// Control fields
	// ---------------------------------------------------------------
	localparam int CTL_MOVE = 0;
	localparam int CTL_PLACE = 1;
	localparam int CTL_SYSFAIL = 2;
	localparam int CTL_CLRHOME = 3;
	localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
	localparam logic [7:0] PWM_RST = 8'h00;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int SHUTDOWN_MS = 100;
	localparam int SHUTDOWN_CYC = SHUTDOWN_MS * 1000 * CLK_MHZ;
	localparam int SEAT_US = 200;
	localparam int SEAT_CYC = SEAT_US * CLK_MHZ;
	// ---------------------------------------------------------------
	// Status display codes
	// ---------------------------------------------------------------
	localparam logic [3:0] CODE_ONLINE = 4'h1;
	localparam logic [3:0] CODE_OFFLINE = 4'h2;
	localparam logic [3:0] CODE_FAULT = 4'hF;
	localparam logic [3:0] CODE_PLACING = 4'h3;
	localparam logic [3:0] CODE_NOHOME = 4'h4;
	typedef enum logic [1:0] {
		PL_IDLE = 2'b00,
		PL_ADVANCE = 2'b01,
		PL_SEAT = 2'b10
	} lsp_place_t;
endpackage : lsp_pkg

// [logic/lsp_pwm.sv]
// Open-loop PWM generator with an 8-bit duty.
`timescale 1ns/100ps
`default_nettype none
module lsp_pwm (
	input wire logic clk,
	input wire logic reset,
	input wire logic enable,
	input wire logic [7:0] duty,
	output logic pwmOut
);
	logic [7:0] cnt_q;
	// ----------------------------------------
	// Free-running ramp compared to duty
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= 8'h00;
			pwmOut <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 8'h01;
			pwmOut <= enable && (cnt_q < duty);
		end
	end
endmodule : lsp_pwm
`default_nettype wire

// [logic/lsp_safety_panel.sv]
// Top of the library safety and panel supervisor with AXI4-Lite registers.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module lsp_safety_panel #(
	parameter int SHUTDOWN_CYCLES = lsp_pkg::SHUTDOWN_CYC,
	parameter int SEAT_CYCLES = lsp_pkg::SEAT_CYC,
	parameter int FACES = 8
) (
	input wire logic clk,
	input wire logic reset,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins
	input wire logic doorClosedPin,
	input wire logic rearClosedPin,
	input wire logic stopPressedPin,
	input wire logic overCurrentPin,
	input wire logic curtainBrokenPin,
	input wire logic homeBeamPin,
	input wire logic faceBeamPin,
	input wire logic upperBeamPin,
	input wire logic lowerBeamPin,
	input wire logic standbyBtnPin,
	input wire logic leftBtnPin,
	input wire logic rightBtnPin,
	input wire logic partSeatedPin,
	output logic motorPowerEn,
	output logic faultLamp,
	output logic standbyLamp,
	output logic [3:0] statusCode,
	output logic jogLeft,
	output logic jogRight,
	output logic gripAdvance,
	output logic gripOpen,
	output logic pusherExtend,
	output logic conveyorPwm,
	output logic ieuPwm
);
	initial begin
		if (SHUTDOWN_CYCLES < 1 || SHUTDOWN_CYCLES > lsp_pkg::SHUTDOWN_CYC) $error("bad SHUTDOWN_CYCLES");
		if (SEAT_CYCLES < 1) $error("bad SEAT_CYCLES");
		if (FACES < 2 || FACES > 16) $error("bad FACES");
	end
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [12:0] pinRaw;
	logic [12:0] pinS;
	assign pinRaw = {partSeatedPin, rightBtnPin, leftBtnPin, standbyBtnPin, lowerBeamPin, upperBeamPin,
		faceBeamPin, homeBeamPin, curtainBrokenPin, overCurrentPin, stopPressedPin, rearClosedPin, doorClosedPin};
	lsp_sync #(.WIDTH(13)) u_sync (
		.clk(clk),
		.reset(reset),
		.pinIn(pinRaw),
		.syncOut(pinS)
	);
	wire doorOpen = !pinS[0];
	wire rearOpen = !pinS[1];
	wire stopPress = pinS[2];
	wire overCur = pinS[3];
	wire curtain = pinS[4];
	wire homeBeam = pinS[5];
	wire faceBeam = pinS[6];
	wire upperBeam = pinS[7];
	wire lowerBeam = pinS[8];
	wire standbyBtn = pinS[9];
	wire leftBtn = pinS[10];
	wire rightBtn = pinS[11];
	wire partSeated = pinS[12];
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] control_q;
	logic [7:0] pwmConv_q;
	logic [7:0] pwmIeu_q;
	logic online_q;
	logic btnPrev_q;
	logic faceHomed_q;
	logic facePrev_q;
	logic [3:0] faceIdx_q;
	logic faceDir_q;
	lsp_pkg::lsp_place_t place_q;
	logic [31:0] seatCnt_q;
	// ----------------------------------------
	// Fault combining; level, so it persists with any cause
	// ----------------------------------------
	wire sysFail = control_q[lsp_pkg::CTL_SYSFAIL];
	wire faultNow = doorOpen || rearOpen || stopPress || overCur || curtain || sysFail;
	wire motionOk = !faultNow;
	wire standbyEdge = standbyBtn && !btnPrev_q;
	wire homeNow = homeBeam && faceBeam;
	wire faceEdge = faceBeam && !facePrev_q;
	// ----------------------------------------
	// AXI4-Lite write path: take AW and W in either order
	// ----------------------------------------
	logic awHeld_q;
	logic wHeld_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire wrGo = awHeld_q && wHeld_q && !s_axi_bvalid;
	wire wrHit = (awAddr_q == lsp_pkg::OFF_CONTROL) || (awAddr_q == lsp_pkg::OFF_PWM_CONV) ||
		(awAddr_q == lsp_pkg::OFF_PWM_IEU);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] st);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) merge[i*8 +: 8] = nv[i*8 +: 8];
		end
	endfunction : merge
	wire hostWr = wrGo && online_q;
	wire [31:0] ctlD = (hostWr && awAddr_q == lsp_pkg::OFF_CONTROL) ? merge(control_q, wData_q, wStrb_q) : control_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= !awHeld_q && !awTake;
			s_axi_wready <= !wHeld_q && !wTake;
			if (awTake) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrGo) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= !wrHit ? 2'b10 : (online_q ? 2'b00 : 2'b10);
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	wire [31:0] statusWord = {16'h0000, statusCode, 2'b00, place_q, gripOpen, lowerBeam, upperBeam, homeNow,
		faceHomed_q, online_q, faultNow, motorPowerEn};
	wire [31:0] rdMux = (s_axi_araddr == lsp_pkg::OFF_CONTROL) ? control_q :
		(s_axi_araddr == lsp_pkg::OFF_STATUS) ? statusWord :
		(s_axi_araddr == lsp_pkg::OFF_PWM_CONV) ? {24'h00_0000, pwmConv_q} :
		(s_axi_araddr == lsp_pkg::OFF_PWM_IEU) ? {24'h00_0000, pwmIeu_q} :
		(s_axi_araddr == lsp_pkg::OFF_POSITION) ? {28'h000_0000, faceIdx_q} : 32'h0000_0000;
	wire rdHit = (s_axi_araddr <= lsp_pkg::OFF_POSITION) && (s_axi_araddr[1:0] == 2'b00);
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Panel, fault and position state
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			control_q <= lsp_pkg::CONTROL_RST;
			pwmConv_q <= lsp_pkg::PWM_RST;
			pwmIeu_q <= lsp_pkg::PWM_RST;
			online_q <= 1'b1;
			btnPrev_q <= 1'b0;
			facePrev_q <= 1'b0;
			faceHomed_q <= 1'b0;
			faceIdx_q <= 4'h0;
			faceDir_q <= 1'b0;
		end else begin
			control_q <= ctlD;
			if (hostWr && awAddr_q == lsp_pkg::OFF_PWM_CONV && wStrb_q[0]) pwmConv_q <= wData_q[7:0];
			if (hostWr && awAddr_q == lsp_pkg::OFF_PWM_IEU && wStrb_q[0]) pwmIeu_q <= wData_q[7:0];
			btnPrev_q <= standbyBtn;
			if (standbyEdge) online_q <= !online_q;
			facePrev_q <= faceBeam;
			if (leftBtn) faceDir_q <= 1'b1;
			else if (rightBtn) faceDir_q <= 1'b0;
			if (homeNow) begin
				faceHomed_q <= 1'b1;
				faceIdx_q <= 4'h0;
			end else if (ctlD[lsp_pkg::CTL_CLRHOME]) begin // Seen home beats a software clear
				faceHomed_q <= 1'b0;
			end else if (faceHomed_q && faceEdge) begin
				faceIdx_q <= faceDir_q ? ((faceIdx_q == 4'h0) ? 4'(FACES - 1) : faceIdx_q - 4'h1) :
					((faceIdx_q == 4'(FACES - 1)) ? 4'h0 : faceIdx_q + 4'h1);
			end
		end
	end
	// ----------------------------------------
	// Place sequence; seat timer is a fixed dwell, not a sensor
	// ----------------------------------------
	wire placeReq = control_q[lsp_pkg::CTL_PLACE] && online_q && motionOk;
	always_ff @(posedge clk) begin
		if (reset) begin
			place_q <= lsp_pkg::PL_IDLE;
			seatCnt_q <= 32'h0000_0000;
		end else if (!motionOk) begin
			place_q <= lsp_pkg::PL_IDLE;
			seatCnt_q <= 32'h0000_0000;
		end else begin
			case (place_q)
				lsp_pkg::PL_IDLE: begin
					if (placeReq) place_q <= lsp_pkg::PL_ADVANCE;
				end
				lsp_pkg::PL_ADVANCE: begin
					if (partSeated) begin
						place_q <= lsp_pkg::PL_SEAT;
						seatCnt_q <= 32'h0000_0000;
					end
				end
				lsp_pkg::PL_SEAT: begin
					seatCnt_q <= seatCnt_q + 32'h0000_0001;
					if (seatCnt_q >= 32'(SEAT_CYCLES - 1)) place_q <= lsp_pkg::PL_IDLE;
				end
				default: place_q <= lsp_pkg::PL_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// Outputs, all registered; drive cut one cycle after fault seen
	// ----------------------------------------
	wire pwmEn = motionOk && online_q;
	wire conveyorRaw;
	wire ieuRaw;
	lsp_pwm u_pwm_conv (.clk(clk), .reset(reset), .enable(pwmEn), .duty(pwmConv_q), .pwmOut(conveyorRaw));
	lsp_pwm u_pwm_ieu (.clk(clk), .reset(reset), .enable(pwmEn), .duty(pwmIeu_q), .pwmOut(ieuRaw));
	wire [3:0] codeD = faultNow ? lsp_pkg::CODE_FAULT : !online_q ? lsp_pkg::CODE_OFFLINE :
		(place_q != lsp_pkg::PL_IDLE) ? lsp_pkg::CODE_PLACING : !faceHomed_q ? lsp_pkg::CODE_NOHOME :
		lsp_pkg::CODE_ONLINE;
	always_ff @(posedge clk) begin
		if (reset) begin
			motorPowerEn <= 1'b0;
			faultLamp <= 1'b0;
			standbyLamp <= 1'b0;
			statusCode <= lsp_pkg::CODE_ONLINE;
			jogLeft <= 1'b0;
			jogRight <= 1'b0;
			gripAdvance <= 1'b0;
			gripOpen <= 1'b0;
			pusherExtend <= 1'b0;
			conveyorPwm <= 1'b0;
			ieuPwm <= 1'b0;
		end else begin
			motorPowerEn <= motionOk;
			faultLamp <= doorOpen || rearOpen || stopPress || sysFail;
			standbyLamp <= !online_q;
			statusCode <= codeD;
			jogLeft <= motionOk && !online_q && leftBtn && !rightBtn;
			jogRight <= motionOk && !online_q && rightBtn && !leftBtn;
			gripAdvance <= motionOk && place_q == lsp_pkg::PL_ADVANCE;
			gripOpen <= motionOk && place_q == lsp_pkg::PL_SEAT;
			pusherExtend <= motionOk && place_q == lsp_pkg::PL_SEAT;
			conveyorPwm <= conveyorRaw && motionOk;
			ieuPwm <= ieuRaw && motionOk;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_fault_cuts_power: assert property (@(posedge clk) disable iff (reset)
		faultNow |=> !motorPowerEn) else $error("motor power not cut on fault");
	a_stop_no_power: assert property (@(posedge clk) disable iff (reset)
		stopPress |=> !motorPowerEn && faultLamp) else $error("stop did not remove power");
	a_curtain_no_move: assert property (@(posedge clk) disable iff (reset)
		curtain |=> !gripAdvance && !jogLeft && !jogRight && !pusherExtend) else $error("motion with curtain broken");
	a_standby_toggle: assert property (@(posedge clk) disable iff (reset)
		standbyEdge |=> online_q != $past(online_q)) else $error("standby press did not toggle");
	a_lamp_offline: assert property (@(posedge clk) disable iff (reset)
		##1 standbyLamp == !$past(online_q)) else $error("standby lamp wrong");
	a_jog_online: assert property (@(posedge clk) disable iff (reset)
		online_q |=> !jogLeft && !jogRight) else $error("jog while online");
	a_home_both: assert property (@(posedge clk) disable iff (reset)
		$rose(faceHomed_q) |-> $past(homeBeam) && $past(faceBeam)) else $error("home without both beams");
	a_place_order: assert property (@(posedge clk) disable iff (reset)
		$rose(gripOpen) |-> $past(gripAdvance) && pusherExtend) else $error("gripper opened out of order");
	a_offline_refuse: assert property (@(posedge clk) disable iff (reset)
		wrGo && !online_q |=> $stable(pwmConv_q) && $stable(pwmIeu_q)) else $error("write taken offline");
	a_fault_lamp: assert property (@(posedge clk) disable iff (reset)
		doorOpen |=> faultLamp && statusCode == lsp_pkg::CODE_FAULT) else $error("door open not shown");
endmodule : lsp_safety_panel
`default_nettype wire

// [logic/lsp_sync.sv]
// Two-stage synchroniser for a bundle of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module lsp_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;
	initial begin
		if (WIDTH < 1) $error("WIDTH must be positive");
	end
	// ----------------------------------------
	// Two flops; first stage read only by second
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= '0;
			syncOut <= '0;
		end else begin
			meta_q <= pinIn;
			syncOut <= meta_q;
		end
	end
endmodule : lsp_sync
`default_nettype wire

// [verif/library_safety_panel_control_tb_top.sv]
// Self-checking bench of the library safety and panel supervisor.
`timescale 1ns/100ps
`default_nettype none
module library_safety_panel_control_tb_top;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [13:0] ctl = 14'h0000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [12:0] pins;
	logic motorPowerEn, faultLamp, standbyLamp, jogLeft, jogRight;
	logic gripAdvance, gripOpen, pusherExtend, conveyorPwm, ieuPwm;
	logic [3:0] statusCode;
	int numErrors = 0;
	int checkCount = 0;
	int causeBit[5] = '{0, 1, 3, 4, 5};

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	lsp_safety_panel #(.SEAT_CYCLES(5)) lsp_safety_panel_inst (.clk(clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .doorClosedPin(pins[0]), .rearClosedPin(pins[1]),
		.stopPressedPin(pins[2]), .overCurrentPin(pins[3]), .curtainBrokenPin(pins[4]),
		.homeBeamPin(pins[5]), .faceBeamPin(pins[6]), .upperBeamPin(pins[7]), .lowerBeamPin(pins[8]),
		.standbyBtnPin(pins[9]), .leftBtnPin(pins[10]), .rightBtnPin(pins[11]),
		.partSeatedPin(pins[12]), .motorPowerEn(motorPowerEn), .faultLamp(faultLamp),
		.standbyLamp(standbyLamp), .statusCode(statusCode), .jogLeft(jogLeft), .jogRight(jogRight),
		.gripAdvance(gripAdvance), .gripOpen(gripOpen), .pusherExtend(pusherExtend),
		.conveyorPwm(conveyorPwm), .ieuPwm(ieuPwm));

	lsp_panel_model lsp_panel_model_inst (.clk(clk), .ctl(ctl), .gripAdvance(gripAdvance), .pins(pins));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checkCount++;
		if (g !== e) begin
			numErrors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Pins pass two synchroniser stages, so give them eight edges to land
	task automatic setCtl(input logic [13:0] v);
		@(posedge clk);
		ctl <= v;
		repeat (8) @(posedge clk);
		#1;
	endtask : setCtl

	task automatic axW(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid && n < 100);
		bready <= 1'h0;
		r = bresp;
		if (bvalid !== 1'h1) chk("write answer", 32'h0000_0001, 32'h0000_0000);
	endtask : axW

	task automatic axR(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'h0;
		end while (!rvalid && n < 100);
		rready <= 1'h0;
		d = rdata;
		r = rresp;
		if (rvalid !== 1'h1) chk("read answer", 32'h0000_0001, 32'h0000_0000);
	endtask : axR

	// Counts high cycles of both PWM outputs over a span
	task automatic pwmCount(input int span, output int hc, output int hi);
		hc = 0;
		hi = 0;
		repeat (span) begin
			@(posedge clk);
			#1;
			hc += (conveyorPwm === 1'h1);
			hi += (ieuPwm === 1'h1);
		end
	endtask : pwmCount

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic tRegs;
		axR(lsp_pkg::OFF_CONTROL, rd, resp);
		chk("control reset", lsp_pkg::CONTROL_RST, rd);
		axR(lsp_pkg::OFF_PWM_IEU, rd, resp);
		chk("duty reset", 32'h0000_0000, rd);
		axR(8'h40, rd, resp);
		chk("unmapped read", 32'h8000_0000, {resp, rd[29:0]});
		axW(8'h40, 32'h0000_0001, resp);
		chk("unmapped write", 2'h2, resp);
		axW(lsp_pkg::OFF_STATUS, 32'h0000_0001, resp);
		chk("status write", 2'h2, resp);
		chk("drive idle", 1'h1, motorPowerEn);
		chk("no home code", lsp_pkg::CODE_NOHOME, statusCode);
	endtask : tRegs

	task automatic tFaults;
		for (int i = 0; i < 5; i++) begin
			setCtl(14'h0001 << causeBit[i]);
			chk("motor drive", 1'h0, motorPowerEn);
			chk("fault code", lsp_pkg::CODE_FAULT, statusCode);
			chk("motion", 3'h0, {jogLeft, jogRight, gripAdvance});
			if (i < 3) chk("fault lamp", 1'h1, faultLamp);
			setCtl(14'h0000);
			chk("drive back", 1'h1, motorPowerEn);
		end
		setCtl(14'h0009);
		setCtl(14'h0008);
		chk("drive held", 1'h0, motorPowerEn);
		setCtl(14'h0006);
		chk("override lamp", 1'h0, faultLamp);
		axW(lsp_pkg::OFF_CONTROL, 32'h0000_0001 << lsp_pkg::CTL_SYSFAIL, resp);
		setCtl(14'h0000);
		chk("failure lamp", 1'h1, faultLamp);
		axW(lsp_pkg::OFF_CONTROL, 32'h0000_0000, resp);
	endtask : tFaults

	task automatic tSensors;
		setCtl(14'h0040);
		axR(lsp_pkg::OFF_STATUS, rd, resp);
		chk("home alone", 1'h0, rd[4]);
		setCtl(14'h00C0);
		axR(lsp_pkg::OFF_STATUS, rd, resp);
		chk("home found", 2'h3, rd[4:3]);
		setCtl(14'h0100);
		axR(lsp_pkg::OFF_STATUS, rd, resp);
		chk("vertical home", 2'h1, rd[6:5]);
		setCtl(14'h0200);
		axR(lsp_pkg::OFF_STATUS, rd, resp);
		chk("lower limit", 2'h2, rd[6:5]);
		axW(lsp_pkg::OFF_CONTROL, 32'h0000_0001 << lsp_pkg::CTL_CLRHOME, resp);
		axR(lsp_pkg::OFF_STATUS, rd, resp);
		chk("home cleared", 1'h0, rd[3]);
		axW(lsp_pkg::OFF_CONTROL, 32'h0000_0000, resp);
		setCtl(14'h00C0);
		axR(lsp_pkg::OFF_POSITION, rd, resp);
		chk("home index", 32'h0000_0000, rd);
	endtask : tSensors

	task automatic tStandby;
		setCtl(14'h1000);
		chk("online jog", 1'h0, jogRight);
		setCtl(14'h0400);
		setCtl(14'h0000);
		chk("standby lamp", 1'h1, standbyLamp);
		chk("offline code", lsp_pkg::CODE_OFFLINE, statusCode);
		axW(lsp_pkg::OFF_CONTROL, 32'h0000_0002, resp);
		chk("offline write", 2'h2, resp);
		axR(lsp_pkg::OFF_CONTROL, rd, resp);
		chk("offline control", 32'h0000_0000, rd);
		setCtl(14'h0800);
		chk("jog left", 2'h2, {jogLeft, jogRight});
		setCtl(14'h1000);
		chk("jog right", 2'h1, {jogLeft, jogRight});
		setCtl(14'h0000);
		setCtl(14'h0080);
		setCtl(14'h0000);
		axR(lsp_pkg::OFF_POSITION, rd, resp);
		chk("face index", 32'h0000_0001, rd);
		setCtl(14'h0400);
		setCtl(14'h0000);
		chk("online again", 1'h0, standbyLamp);
		chk("online code", lsp_pkg::CODE_ONLINE, statusCode);
	endtask : tStandby

	task automatic tPlace;
		int n;
		setCtl(14'h2000);
		axW(lsp_pkg::OFF_CONTROL, 32'h0000_0002, resp);
		chk("online write", 2'h0, resp);
		n = 0;
		while (gripAdvance !== 1'h1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("advance first", 3'h4, {gripAdvance, gripOpen, pusherExtend});
		chk("placing code", lsp_pkg::CODE_PLACING, statusCode);
		repeat (20) @(posedge clk);
		#1;
		chk("held before seat", 2'h0, {gripOpen, pusherExtend});
		n = 0;
		while (gripOpen !== 1'h1 && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("release and push", 2'h3, {gripOpen, pusherExtend});
		setCtl(14'h2008);
		chk("stop halts", 2'h0, {gripAdvance, motorPowerEn});
		axW(lsp_pkg::OFF_CONTROL, 32'h0000_0000, resp);
		setCtl(14'h0000);
	endtask : tPlace

	task automatic tPwm;
		int hc;
		int hi;
		axW(lsp_pkg::OFF_PWM_CONV, 32'h0000_0040, resp);
		axW(lsp_pkg::OFF_PWM_IEU, 32'h0000_00C0, resp);
		pwmCount(512, hc, hi);
		chk("conveyor duty", 1'h1, hc >= 120 && hc <= 136);
		chk("insert duty", 1'h1, hi >= 376 && hi <= 392);
		setCtl(14'h0008);
		pwmCount(300, hc, hi);
		chk("pwm cut", 32'h0000_0000, hc + hi);
		setCtl(14'h0000);
	endtask : tPwm

	task automatic conclude;
		$display("checks %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// Main sequence; reset is held for four edges
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'h0;
		repeat (3) @(posedge clk);
		tRegs();
		tFaults();
		tSensors();
		tStandby();
		tPlace();
		tPwm();
		conclude();
	end

	// Watchdog well beyond the thousand or so cycles the scenarios need
	initial begin
		repeat (40000) @(posedge clk);
		numErrors++;
		conclude();
	end
endmodule : library_safety_panel_control_tb_top
`default_nettype wire

// [verif/lsp_panel_model.sv]
// Operator panel, interlock switches and beam sensors facing the supervisor.
`timescale 1ns/100ps
`default_nettype none
module lsp_panel_model (
	input wire logic clk,
	input wire logic [13:0] ctl,
	input wire logic gripAdvance,
	output logic [12:0] pins
);
	// Request bits: 0 door open, 1 rear panel off, 2 override pulled, 3 stop,
	// 4 overcurrent, 5 curtain, 6 home, 7 face, 8 upper, 9 lower,
	// 10 standby, 11 left, 12 right, 13 slow seating
	logic [13:0] ctl_q = 14'h0000;
	logic [5:0] seat_q = 6'h00;
	// Switches settle one cycle after a request; seat sensor trails the advance
	always_ff @(posedge clk) begin
		ctl_q <= ctl;
		seat_q <= !gripAdvance ? 6'h00 : (seat_q == 6'h3F ? seat_q : seat_q + 6'h01);
	end
	// Door switch reads high while closed
	assign pins[0] = ~ctl_q[0];
	// Pulled-out override reads as closed with the panel off
	assign pins[1] = ~ctl_q[1] | ctl_q[2];
	assign pins[11:2] = ctl_q[12:3];
	// Slow mode makes the gripper wait long before partial seating
	assign pins[12] = seat_q >= (ctl_q[13] ? 6'h1E : 6'h03);
endmodule : lsp_panel_model
`default_nettype wire
